/* core/drmap_ctrl.sv */
// DRAM row map, address mux and EDO detect read sequencer.
// Assumes an APB master on pclk and a simple host request port.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module drmap_ctrl
  import drmap_pkg::*;
#(
  parameter int REFRESH_CYCLES = drmap_pkg::REFRESH_CYC
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // APB
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Host request port
  input  wire drmap_pkg::drmap_req_s host_req,
  output drmap_pkg::drmap_rsp_s     host_rsp,
  output logic                      host_ready,
  // DRAM pins
  output logic      [11:0]          dram_mux_addr,
  output logic      [7:0]           ras_n,
  output logic      [7:0]           cas_n,
  output logic                      we_n,
  input  wire logic [63:0]          dram_data_lines_in,
  output logic      [63:0]          dram_data_lines_out,
  output logic                      dram_data_lines_oe,
  output logic                      refresh_tick
);

  initial begin
    // Data must be latched only after the detect CAS has been released
    if (REFRESH_CYCLES < DETECT_CAS_CYC + 2 || REFRESH_CYCLES > 65536) $error("REFRESH_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [63:0]  row_boundary_reg;
  logic [7:0]   row_type_reg;
  logic [7:0]   row_mux_reg;
  logic [31:0]  ctrl_reg;
  logic         edo_detect_mode;
  logic [3:0]   dram_timing_cfg;
  logic         apb_wr;

  assign apb_wr          = psel && penable && pwrite && pready;
  assign edo_detect_mode = ctrl_reg[CTRL_DETECT_BIT];
  assign dram_timing_cfg = ctrl_reg[CTRL_TIM_LSB +: CTRL_TIM_W];
  assign pready          = 1'b1;

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_boundary_reg <= 64'h0;
      row_type_reg     <= ROW_TYPE_RST;
      row_mux_reg      <= 8'h00;
      ctrl_reg         <= CTRL_RST;
    end else if (clk_en && apb_wr) begin
      if (paddr == OFF_BOUND_LO) begin
        row_boundary_reg[31:0] <= pwdata;
      end else if (paddr == OFF_BOUND_HI) begin
        row_boundary_reg[63:32] <= pwdata;
      end else if (paddr == OFF_ROW_TYPE) begin
        row_type_reg <= pwdata[7:0];
      end else if (paddr == OFF_ROW_MUX) begin
        row_mux_reg <= pwdata[7:0];
      end else if (paddr == OFF_CTRL) begin
        ctrl_reg <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Row decode
  // ----------------------------------------------------------------
  logic [7:0]   row_hit;
  logic         hit_pci;

  drmap_row_decode #(
    .ROWS (NUM_ROWS)
  ) u_dec (
    .addr       (host_req.addr),
    .bounds     (row_boundary_reg),
    .gap_lo_en  (ctrl_reg[CTRL_GAP_LO_BIT]),
    .gap_hi_en  (ctrl_reg[CTRL_GAP_HI_BIT]),
    .row_onehot (row_hit),
    .to_pci     (hit_pci)
  );

  // ----------------------------------------------------------------
  // Address mux functions
  // ----------------------------------------------------------------
  function automatic logic [11:0] row_addr(input logic [28:0] a, input logic m64);
    row_addr = {m64 ? a[25] : a[24], a[23], a[21], a[20:12]};
  endfunction

  function automatic logic [11:0] col_addr(input logic [28:0] a);
    col_addr = {a[26], a[24], a[22], a[11:3]};
  endfunction

  // ----------------------------------------------------------------
  // Refresh interval counter
  // ----------------------------------------------------------------
  logic [15:0]  ref_cnt_reg;

  // Free running 15.6 us tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (ref_cnt_reg == 16'(REFRESH_CYCLES - 1)) begin
        ref_cnt_reg <= 16'h0000;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 16'h0001;
      end
    end
  end
  assign refresh_tick = (ref_cnt_reg == 16'(REFRESH_CYCLES - 1));

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  drmap_state_e state_reg;
  drmap_req_s   req_reg;
  logic [7:0]   row_sel_reg;
  logic [3:0]   cnt_reg;
  logic [3:0]   cas_len;
  logic         sel_edo;
  logic         take;

  assign host_ready = (state_reg == DRMAP_IDLE);
  assign take       = clk_en && host_ready && host_req.valid;
  assign sel_edo    = |(row_sel_reg & row_type_reg);
  // Per-row type plus global timing sets the CAS width
  assign cas_len    = (sel_edo ? 4'(EDO_CAS_CYC) : 4'(FPM_CAS_CYC)) + dram_timing_cfg;

  // State and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= DRMAP_IDLE;
      req_reg     <= '0;
      row_sel_reg <= 8'h00;
      cnt_reg     <= 4'h0;
    end else if (clk_en) begin
      case (state_reg)
        DRMAP_IDLE: begin
          if (host_req.valid && !hit_pci) begin
            req_reg     <= host_req;
            row_sel_reg <= row_hit;
            cnt_reg     <= 4'h0;
            state_reg   <= DRMAP_ROW;
          end
        end
        DRMAP_ROW: begin
          cnt_reg <= 4'h0;
          if (edo_detect_mode && !req_reg.write) begin
            state_reg <= DRMAP_WAIT1;
          end else begin
            state_reg <= DRMAP_COL;
          end
        end
        DRMAP_COL: begin
          if (cnt_reg == cas_len - 4'h1) begin
            state_reg <= DRMAP_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        DRMAP_WAIT1: begin
          cnt_reg <= 4'h0;
          if (refresh_tick) begin
            state_reg <= DRMAP_DCAS;
          end
        end
        DRMAP_DCAS: begin
          if (cnt_reg == 4'(DETECT_CAS_CYC - 1)) begin
            state_reg <= DRMAP_WAIT2;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        DRMAP_WAIT2: begin
          if (refresh_tick) begin
            state_reg <= DRMAP_IDLE;
          end
        end
        default: begin
          state_reg <= DRMAP_IDLE;
        end
      endcase
    end
  end

  // Response and data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rsp <= '0;
    end else if (clk_en) begin
      host_rsp.done   <= 1'b0;
      host_rsp.to_pci <= 1'b0;
      if (take && hit_pci) begin
        host_rsp.done   <= 1'b1;
        host_rsp.to_pci <= 1'b1;
      end else if (state_reg == DRMAP_WAIT2 && refresh_tick) begin
        host_rsp.done  <= 1'b1;
        host_rsp.rdata <= dram_data_lines_in;
      end else if (state_reg == DRMAP_COL && cnt_reg == cas_len - 4'h1) begin
        host_rsp.done  <= 1'b1;
        if (!req_reg.write) begin
          host_rsp.rdata <= dram_data_lines_in;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // DRAM pin drive
  // ----------------------------------------------------------------
  logic m64_sel;
  assign m64_sel = |(row_sel_reg & row_mux_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_mux_addr       <= 12'h000;
      ras_n               <= 8'hFF;
      cas_n               <= 8'hFF;
      we_n                <= 1'b1;
      dram_data_lines_out <= 64'h0;
      dram_data_lines_oe  <= 1'b0;
    end else if (clk_en) begin
      ras_n <= (state_reg == DRMAP_IDLE) ? 8'hFF : ~row_sel_reg;
      if (state_reg == DRMAP_ROW) begin
        dram_mux_addr <= row_addr(req_reg.addr, m64_sel);
      end else if (state_reg != DRMAP_IDLE) begin
        dram_mux_addr <= col_addr(req_reg.addr);
      end
      cas_n <= (state_reg == DRMAP_COL || state_reg == DRMAP_DCAS) ? 8'h00 : 8'hFF;
      we_n  <= !(state_reg == DRMAP_COL && req_reg.write);
      dram_data_lines_oe  <= state_reg == DRMAP_COL && req_reg.write;
      dram_data_lines_out <= req_reg.wdata;
    end
  end

  // ----------------------------------------------------------------
  // APB read
  // ----------------------------------------------------------------
  always_comb begin
    pslverr = 1'b0;
    if (paddr == OFF_BOUND_LO) begin
      prdata = row_boundary_reg[31:0];
    end else if (paddr == OFF_BOUND_HI) begin
      prdata = row_boundary_reg[63:32];
    end else if (paddr == OFF_ROW_TYPE) begin
      prdata = {24'h0, row_type_reg};
    end else if (paddr == OFF_ROW_MUX) begin
      prdata = {24'h0, row_mux_reg};
    end else if (paddr == OFF_CTRL) begin
      prdata = ctrl_reg;
    end else if (paddr == OFF_STATUS) begin
      prdata = {14'h0, host_rsp.to_pci, !host_ready, row_sel_reg, 2'h0, state_reg};
    end else begin
      prdata  = 32'h0;
      pslverr = psel && penable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ras_onehot;
    @(posedge pclk) disable iff (!presetn)
    $onehot0(~ras_n);
  endproperty
  a_ras_onehot: assert property (p_ras_onehot) else $error("more than one row strobe");

  property p_dcas_len;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == DRMAP_WAIT1 && refresh_tick) |=> (state_reg == DRMAP_DCAS) [*3];
  endproperty
  a_dcas_len: assert property (p_dcas_len) else $error("detect CAS not three clocks");

  property p_write_normal;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == DRMAP_ROW && req_reg.write) |-> state_reg != DRMAP_WAIT1 ##1 state_reg == DRMAP_COL || !clk_en;
  endproperty
  a_write_normal: assert property (p_write_normal) else $error("write entered detect");

  property p_pci_no_ras;
    @(posedge pclk) disable iff (!presetn)
    (take && hit_pci) |=> host_rsp.to_pci && state_reg == DRMAP_IDLE;
  endproperty
  a_pci_no_ras: assert property (p_pci_no_ras) else $error("hole access not sent to PCI");

  property p_reset_fpm;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> row_type_reg == 8'h00;
  endproperty
  a_reset_fpm: assert property (p_reset_fpm) else $error("rows not FPM after reset");

  property p_col_map;
    @(posedge pclk) disable iff (!presetn)
    (cas_n != 8'hFF) |->
      dram_mux_addr == {req_reg.addr[26], req_reg.addr[24], req_reg.addr[22], req_reg.addr[11:3]};
  endproperty
  a_col_map: assert property (p_col_map) else $error("column map wrong");

  property p_row_map;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && state_reg == DRMAP_ROW) |=> !clk_en || dram_mux_addr[8:0] == req_reg.addr[20:12];
  endproperty
  a_row_map: assert property (p_row_map) else $error("row map wrong");

  property p_tick_period;
    @(posedge pclk) disable iff (!presetn)
    refresh_tick && clk_en |=> !refresh_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("refresh tick too close");

endmodule

/* core/drmap_pkg.sv */
// Package for the DRAM row map and EDO detect block.
// Assumes a single 50 MHz clock domain and an APB register port.
package drmap_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int        NUM_ROWS       = 8;
  localparam int        HADDR_W        = 29;          // 512 MB space
  localparam int        MA_W           = 12;
  localparam int        DATA_W         = 64;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BOUND_LO  = 8'h00;       // Rows 0..3 boundaries
  localparam logic [7:0] OFF_BOUND_HI  = 8'h04;       // Rows 4..7 boundaries
  localparam logic [7:0] OFF_ROW_TYPE  = 8'h08;       // Bit per row, 1 = EDO
  localparam logic [7:0] OFF_ROW_MUX   = 8'h0C;       // Bit per row, 1 = 64M mux
  localparam logic [7:0] OFF_CTRL      = 8'h10;       // Detect, gaps, timing
  localparam logic [7:0] OFF_STATUS    = 8'h14;       // Busy, last row, pci flag

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int        CTRL_DETECT_BIT = 0;
  localparam int        CTRL_GAP_LO_BIT = 1;          // 512K-640K gap
  localparam int        CTRL_GAP_HI_BIT = 2;          // 15M-16M gap
  localparam int        CTRL_TIM_LSB    = 4;
  localparam int        CTRL_TIM_W      = 4;
  localparam logic [7:0] ROW_TYPE_RST   = 8'h00;      // All FPM
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Fixed address regions (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [28:0] VIDEO_LO     = 29'h000A_0000;
  localparam logic [28:0] VIDEO_HI     = 29'h000C_0000;
  localparam logic [28:0] GAP_LO_LO    = 29'h0008_0000;
  localparam logic [28:0] GAP_LO_HI    = 29'h000A_0000;
  localparam logic [28:0] GAP_HI_LO    = 29'h00F0_0000;
  localparam logic [28:0] GAP_HI_HI    = 29'h0100_0000;
  localparam int        BOUND_SHIFT    = 22;          // 4 MB units

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int        CLK_MHZ        = 50;
  localparam int        REFRESH_NS     = 15600;
  localparam int        REFRESH_CYC    = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int        DETECT_CAS_CYC = 3;
  localparam int        FPM_CAS_CYC    = 3;
  localparam int        EDO_CAS_CYC    = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DRMAP_IDLE  = 6'b000001,
    DRMAP_ROW   = 6'b000010,
    DRMAP_COL   = 6'b000100,
    DRMAP_WAIT1 = 6'b001000,
    DRMAP_DCAS  = 6'b010000,
    DRMAP_WAIT2 = 6'b100000
  } drmap_state_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [28:0]       addr;
    logic [63:0]       wdata;
  } drmap_req_s;

  typedef struct packed {
    logic              done;
    logic              to_pci;
    logic [63:0]       rdata;
  } drmap_rsp_s;

endpackage

/* core/drmap_row_decode.sv */
// Row decoder: picks the DRAM row for an address, or flags it for PCI.
// Assumes boundaries are cumulative and non-decreasing in 4 MB units.
`timescale 1ns/1ps
module drmap_row_decode
  import drmap_pkg::*;
#(
  parameter int ROWS = drmap_pkg::NUM_ROWS
) (
  // Inputs
  input  wire logic [drmap_pkg::HADDR_W-1:0] addr,
  input  wire logic [ROWS*8-1:0]             bounds,
  input  wire logic                          gap_lo_en,
  input  wire logic                          gap_hi_en,
  // Outputs
  output logic      [ROWS-1:0]               row_onehot,
  output logic                               to_pci
);

  initial begin
    if (ROWS < 1 || ROWS > 8) $error("ROWS must be 1..8");
  end

  // ----------------------------------------------------------------
  // Lowest row whose boundary exceeds the address
  // ----------------------------------------------------------------
  logic [6:0] unit;
  logic       hole;
  assign unit = addr[HADDR_W-1:BOUND_SHIFT];
  assign hole = (addr >= VIDEO_LO && addr < VIDEO_HI)
              || (gap_lo_en && addr >= GAP_LO_LO && addr < GAP_LO_HI)
              || (gap_hi_en && addr >= GAP_HI_LO && addr < GAP_HI_HI);

  always_comb begin
    logic found;
    found      = 1'b0;
    row_onehot = '0;
    for (int i = 0; i < ROWS; i++) begin
      if (!found && {1'b0, unit} < bounds[i*8 +: 8]) begin
        row_onehot[i] = 1'b1;
        found         = 1'b1;
      end
    end
    if (hole) begin
      row_onehot = '0;
    end
    to_pci = hole || !found;
  end

endmodule

/* verification/drmap_simm_model.sv */
// Behavioural model of the SIMM rows on the DRAM pins.
// Assumes registered strobes from the controller, seen on pclk.
`timescale 1ns/1ps
module drmap_simm_model (
  // Clock
  input  wire logic        pclk,
  // Strobes and address
  input  wire logic [7:0]  ras_n,
  input  wire logic [7:0]  cas_n,
  input  wire logic        we_n,
  input  wire logic [11:0] mux_addr,
  // Data and fitted row types
  input  wire logic [63:0] wdata,
  input  wire logic [7:0]  edo_rows,
  output logic      [63:0] rdata
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [63:0] mem [logic [26:0]];
  logic [7:0]  ras_q = 8'hFF;
  logic [2:0]  row   = 3'h0;
  logic [11:0] ra    = 12'h000;
  logic [63:0] q     = 64'h0;
  logic [63:0] look;
  logic        hold  = 1'b0;

  // Cell at the open row and the column now on the pins
  always @* begin
    look = 64'h0;
    if (mem.exists({row, ra, mux_addr})) look = mem[{row, ra, mux_addr}];
  end

  // Row latch on RAS fall, then store or fetch on each CAS clock
  always @(posedge pclk) begin
    ras_q <= ras_n;
    if (ras_n == 8'hFF) begin
      hold <= 1'b0;
    end else if (ras_q == 8'hFF) begin
      for (int i = 0; i < 8; i++) begin
        if (!ras_n[i]) row <= 3'(i);
      end
      ra <= mux_addr;
    end else if (cas_n != 8'hFF) begin
      if (!we_n) begin
        mem[{row, ra, mux_addr}] = wdata;
      end else begin
        q    <= look;
        hold <= edo_rows[row]; // Only EDO parts keep driving after CAS rises
      end
    end
  end

  // Data while CAS is low, EDO hold after it, else the pull-down level
  assign rdata = (cas_n != 8'hFF && we_n) ? look : (hold ? q : 64'h0);
endmodule

/* verification/drmap_bench.sv */
// Self-checking bench for the DRAM row map and EDO detect controller.
// Assumes the SIMM model on the DRAM pins and a 50 MHz pclk.
`timescale 1ns/1ps
module drmap_bench;
  import drmap_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int          RC = 8;
  localparam logic [28:0] CORNER [7] = '{29'h0009_FFF8, 29'h000A_0000, 29'h00F0_0000, 29'h0FFF_FFF8,
                                         29'h1000_0000, 29'h003F_FFF8, 29'h0040_0000};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, host_ready, we_n, oe, tick, e, pci_seen, ce;
  logic [7:0]  paddr, ras_n, cas_n, ras_seen, mux_byte, rt_byte, edo_rows;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] mux, row_seen, col_seen;
  logic [63:0] din, dout, d;
  logic [28:0] a;
  logic [3:0]  nib, cfg;
  drmap_req_s  req;
  drmap_rsp_s  rsp;
  logic [7:0]  bnd [8] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40};
  int          err_count, samples_checked, seed, ccnt, r;

  drmap_ctrl #(.REFRESH_CYCLES(RC)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_req(req), .host_rsp(rsp), .host_ready(host_ready), .dram_mux_addr(mux), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .dram_data_lines_in(din), .dram_data_lines_out(dout),
    .dram_data_lines_oe(oe), .refresh_tick(tick));
  drmap_simm_model i_simm (.pclk(pclk), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mux_addr(mux),
    .wdata(oe ? dout : ~dout), .edo_rows(edo_rows), .rdata(din));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Pin monitor: CAS cycles, row and column address, selected row
  always @(negedge pclk) begin
    if (cas_n != 8'hFF) begin
      ccnt++;
      col_seen = mux;
    end else if (ras_n != 8'hFF && ras_seen == 8'hFF) begin
      row_seen = mux;
    end
    if (ras_n != 8'hFF) ras_seen = ras_n;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", s, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic hang(input int k);
    if (k >= 300) begin
      chk("handshake", 0, 1);
      conclude();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 300);
    hang(k);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic host(input logic w);
    int k;
    req <= '{1'b1, w, a, d};
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (host_ready !== 1'b1 && k < 300);
    hang(k);
    @(posedge pclk);
    req.valid <= 1'b0;
    ccnt = 0;
    ras_seen = 8'hFF;
    pci_seen = 1'b0;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
      pci_seen |= rsp.to_pci;
    end while (rsp.done !== 1'b1 && k < 300);
    hang(k);
    repeat (2) @(negedge pclk);
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic int row_of(input logic [28:0] ad);
    for (int i = 0; i < 8; i++) begin
      if ({1'b0, ad[28:22]} < bnd[i]) return i;
    end
    return 8;
  endfunction

  function automatic logic pci_exp(input logic [28:0] ad);
    return row_of(ad) == 8 || (ad >= VIDEO_LO && ad < VIDEO_HI) || (cfg[1] && ad >= GAP_LO_LO && ad < GAP_LO_HI)
      || (cfg[2] && ad >= GAP_HI_LO && ad < GAP_HI_HI);
  endfunction

  // One host access with all pin and response comparisons
  task automatic access(input logic w, input logic det, input logic [63:0] x);
    host(w);
    r = row_of(a);
    if (pci_exp(a)) begin
      chk("to_pci", pci_seen, 1);
      chk("ras_n", ras_seen, 8'hFF);
    end else begin
      chk("to_pci", pci_seen, 0);
      chk("ras_n", ras_seen, {56'h0, ~(8'h01 << r)});
      chk("row addr", row_seen, {mux_byte[r] ? a[25] : a[24], a[23], a[21], a[20:12]});
      chk("col addr", col_seen, {a[26], a[24], a[22], a[11:3]});
      chk("cas cycles", 64'(ccnt), 64'(det && !w ? DETECT_CAS_CYC
          : (rt_byte[r] ? EDO_CAS_CYC : FPM_CAS_CYC) + nib));
      if (!w) chk("rdata", rsp.rdata, x);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req, presetn, edo_rows} = '0;
    {err_count, samples_checked, ccnt} = '0;
    seed = 15047;
    ce = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ras_n", ras_n, 8'hFF);
    chk("cas_n", cas_n, 8'hFF);
    chk("oe", oe, 0);
    chk("host_ready", host_ready, 1);
    apb(0, OFF_ROW_TYPE, 0);
    chk("row type", q, 64'(ROW_TYPE_RST));
    apb(1, OFF_BOUND_LO, {bnd[3], bnd[2], bnd[1], bnd[0]});
    apb(1, OFF_BOUND_HI, {bnd[7], bnd[6], bnd[5], bnd[4]});
    apb(0, OFF_BOUND_HI, 0);
    chk("bounds hi", q, {bnd[7], bnd[6], bnd[5], bnd[4]});
    apb(0, 8'h18, 0);
    chk("pslverr", e, 1);
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    apb(1, OFF_ROW_MUX, 32'h0000_00A5);
    ce <= 1'b1;
    apb(0, OFF_ROW_MUX, 0);
    chk("frozen write", q, 0);
    // Random and corner accesses, each written then read back
    for (int i = 0; i < 24; i++) begin
      nib = 4'($random(seed) & 3);
      cfg = 4'($random(seed)) & 4'h6;
      mux_byte = 8'($random(seed));
      rt_byte = 8'($random(seed));
      apb(1, OFF_ROW_MUX, {24'h0, mux_byte});
      apb(1, OFF_ROW_TYPE, {24'h0, rt_byte});
      apb(1, OFF_CTRL, {24'h0, nib, cfg});
      a = i < 7 ? CORNER[i] : 29'($random(seed)) & 29'h1FFF_FFF8;
      d = {32'($random(seed)), 32'($random(seed))};
      access(1, 0, d);
      access(0, 0, d);
    end
    // Detect mode: all rows marked EDO, writes then reads of every row
    edo_rows = 8'($random(seed));
    rt_byte = 8'hFF;
    cfg = 4'h0;
    apb(1, OFF_ROW_TYPE, 32'h0000_00FF);
    apb(1, OFF_CTRL, {24'h0, nib, 4'h1});
    for (int j = 0; j < 16; j++) begin
      a = (29'(j % 8) << 25) | 29'h0010_0000;
      d = {8'(j % 8), 56'hA5_5A3C_C3F0_0F96};
      access(j < 8, 1, edo_rows[j % 8] ? d : 64'h0);
    end
    // Status when idle after the last access to row 7
    apb(0, OFF_STATUS, 0);
    chk("status", q, {16'h0, 8'h80, 2'h0, 6'(DRMAP_IDLE)});
    // Spacing of the refresh tick
    r = 0;
    while (tick !== 1'b1 && r < 300) begin
      @(negedge pclk);
      r++;
    end
    @(negedge pclk);
    r = 1;
    while (tick !== 1'b1 && r < 300) begin
      @(negedge pclk);
      r++;
    end
    chk("tick period", 64'(r), 64'(RC));
    conclude();
  end
endmodule
